// File: src/tcoc_pkg.sv
// Package for the compare output stage of a 16-bit timer.
// Assumes one 25 MHz clock and a plain register port beside the timer core.
package tcoc_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [1:0] TCOC_ADDR_CTRL_A    = 2'h0; // Mode byte of the channels.
  localparam logic [1:0] TCOC_ADDR_STATUS    = 2'h1; // Compare output levels and pin driver enables.
  localparam logic [7:0] TCOC_CTRL_A_RESET   = 8'h00;
  localparam int         TCOC_POS_MODE_A     = 6;
  localparam int         TCOC_POS_MODE_B     = 4;
  localparam int         TCOC_POS_FORCE_A    = 3;
  localparam int         TCOC_POS_FORCE_B    = 2;
  localparam int         TCOC_POS_WGM_LO     = 0;
  localparam logic [7:0] TCOC_CTRL_A_RW_MASK = 8'hf3; // Force bits read as zero.

  // ----------------------------------------------------------------------
  // Waveform modes and output codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] TCOC_WGM_FAST_TOGGLE = 4'hf;
  localparam logic [1:0] TCOC_COM_OFF         = 2'h0;
  localparam logic [1:0] TCOC_COM_TOGGLE      = 2'h1;
  localparam logic [1:0] TCOC_COM_CLEAR       = 2'h2;
  localparam logic [1:0] TCOC_COM_SET         = 2'h3;
  localparam logic [15:0] TCOC_BOTTOM         = 16'h0000;

  typedef enum logic [1:0] {
    TCOC_WAVE_NONPWM = 2'b00,
    TCOC_WAVE_FAST   = 2'b01,
    TCOC_WAVE_OTHER  = 2'b10
  } tcoc_wave_t;

  // Timer core view that the stage samples each cycle.
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] top;
    logic        match_a;
    logic        match_b;
    logic [15:0] cmp_value_a;
    logic [15:0] cmp_value_b;
  } tcoc_timer_t;

  // Register port from software.
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tcoc_bus_t;

endpackage : tcoc_pkg

// File: src/tcoc_output_ctrl.sv
// Compare output stage of a 16-bit timer, channels A and B.
// Assumes the timer core supplies count, top, match strobes and compare values
// synchronous to clk, and the port logic supplies the pin direction bits.
//
// Functional notes
// - Any bit of mode A set routes compare output A onto its pin, except code 01 in fast PWM modes other than 15.
// - Any bit of mode B set routes compare output B onto its pin, except code 01 in fast PWM.
// - Pin driver enabled only while its direction bit is set.
// - Mode field meaning depends on the selected waveform mode.
// - Non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM 01: toggle A only in mode 15; B stays off.
// - Fast PWM 10: clear on match, set at bottom.
// - Fast PWM 11: set on match, clear at bottom.
// - Fast PWM: match ignored when compare equals top with upper bit set.
`timescale 1ns/10ps
module tcoc_output_ctrl
  import tcoc_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire tcoc_pkg::tcoc_bus_t   bus,
  output logic [7:0]                 rdata,
  input  wire tcoc_pkg::tcoc_timer_t tmr,
  input  wire logic [1:0]            wgm_hi,
  input  wire logic                  dir_a,
  input  wire logic                  dir_b,
  input  wire logic                  port_a,
  input  wire logic                  port_b,
  output logic                       pin_a,
  output logic                       pin_a_oe,
  output logic                       pin_b,
  output logic                       pin_b_oe,
  output logic                       cmp_output_a,
  output logic                       cmp_output_b
);
  import tcoc_pkg::*;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Waveform mode class; fast PWM modes are 5, 6, 7, 14 and 15.
  function automatic tcoc_wave_t wave_of(input logic [3:0] wgm);
    unique case (wgm)
      4'h0, 4'h4, 4'hc: wave_of = TCOC_WAVE_NONPWM;
      4'h5, 4'h6, 4'h7, 4'he, 4'hf: wave_of = TCOC_WAVE_FAST;
      default: wave_of = TCOC_WAVE_OTHER;
    endcase
  endfunction : wave_of

  // Next level of one compare output.
  function automatic logic out_next(input logic       cur,
                                    input logic [1:0] com,
                                    input tcoc_wave_t wave,
                                    input logic       match,
                                    input logic       at_top,
                                    input logic       bottom,
                                    input logic       is_a,
                                    input logic [3:0] wgm);
    logic res;
    res = cur;
    unique case (wave)
      TCOC_WAVE_NONPWM: begin
        if (match) begin
          unique case (com)
            TCOC_COM_TOGGLE: res = ~cur;
            TCOC_COM_CLEAR:  res = 1'b0;
            TCOC_COM_SET:    res = 1'b1;
            default:         res = cur;
          endcase
        end
      end
      TCOC_WAVE_FAST: begin
        unique case (com)
          // Toggle only channel A, mode 15.
          TCOC_COM_TOGGLE: begin
            if (match && is_a && (wgm == TCOC_WGM_FAST_TOGGLE)) res = ~cur;
          end
          TCOC_COM_CLEAR: begin
            if (bottom) res = 1'b1;
            else if (match && !at_top) res = 1'b0;
          end
          TCOC_COM_SET: begin
            if (bottom) res = 1'b0;
            else if (match && !at_top) res = 1'b1;
          end
          default: res = cur;
        endcase
      end
      default: res = cur;
    endcase
    // Any case not listed above holds the present level.
    out_next = res;
  endfunction : out_next

  // ----------------------------------------------------------------------
  // Control register and read port
  // ----------------------------------------------------------------------
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic [7:0] next_rdata;
  logic       force_a;
  logic       force_b;
  logic       next_force_a;
  logic       next_force_b;

  // Force bits are one-cycle strobes held in force_a and force_b, not in ctrl, so they read as zero.
  always_comb begin
    next_ctrl    = ctrl;
    next_force_a = 1'b0;
    next_force_b = 1'b0;
    next_rdata   = 8'h00;
    if (bus.wr && bus.addr == TCOC_ADDR_CTRL_A) begin
      next_ctrl    = bus.wdata & TCOC_CTRL_A_RW_MASK;
      next_force_a = bus.wdata[TCOC_POS_FORCE_A];
      next_force_b = bus.wdata[TCOC_POS_FORCE_B];
    end
    if (bus.rd) begin
      unique case (bus.addr)
        TCOC_ADDR_CTRL_A: next_rdata = ctrl;
        TCOC_ADDR_STATUS: next_rdata = {4'h0, pin_b_oe, pin_a_oe, cmp_output_b, cmp_output_a};
        default:          next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl    <= TCOC_CTRL_A_RESET;
      force_a <= 1'b0;
      force_b <= 1'b0;
      rdata   <= 8'h00;
    end else begin
      ctrl    <= next_ctrl;
      force_a <= next_force_a;
      force_b <= next_force_b;
      rdata   <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Waveform outputs and pins
  // ----------------------------------------------------------------------
  logic [1:0] mode_a;
  logic [1:0] mode_b;
  logic [3:0] wgm;
  tcoc_wave_t wave;
  logic       bottom;
  logic       next_out_a;
  logic       next_out_b;
  logic       next_pin_a;
  logic       next_pin_b;
  logic       next_oe_a;
  logic       next_oe_b;
  logic       own_a;
  logic       own_b;

  assign mode_a = ctrl[TCOC_POS_MODE_A +: 2];
  assign mode_b = ctrl[TCOC_POS_MODE_B +: 2];
  assign wgm    = {wgm_hi, ctrl[TCOC_POS_WGM_LO +: 2]};
  // Mode class selects the code table.
  assign wave   = wave_of(wgm);
  // Bottom is the counter at zero.
  assign bottom = (tmr.count == TCOC_BOTTOM);

  always_comb begin
    next_out_a = out_next(cmp_output_a, mode_a, wave,
                          tmr.match_a || (force_a && wave == TCOC_WAVE_NONPWM),
                          tmr.cmp_value_a == tmr.top && mode_a[1], bottom, 1'b1, wgm);
    next_out_b = out_next(cmp_output_b, mode_b, wave,
                          tmr.match_b || (force_b && wave == TCOC_WAVE_NONPWM),
                          tmr.cmp_value_b == tmr.top && mode_b[1], bottom, 1'b0, wgm);
    // Channel A takeover; fast PWM code 01 keeps the port unless in mode 15.
    own_a      = (mode_a != TCOC_COM_OFF) &&
                 !(wave == TCOC_WAVE_FAST && mode_a == TCOC_COM_TOGGLE &&
                   wgm != TCOC_WGM_FAST_TOGGLE);
    // Channel B takeover; fast PWM code 01 always keeps the port.
    own_b      = (mode_b != TCOC_COM_OFF) &&
                 !(wave == TCOC_WAVE_FAST && mode_b == TCOC_COM_TOGGLE);
    next_pin_a = own_a ? next_out_a : port_a;
    next_pin_b = own_b ? next_out_b : port_b;
    next_oe_a  = dir_a;
    next_oe_b  = dir_b;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_output_a <= 1'b0;
      cmp_output_b <= 1'b0;
      pin_a        <= 1'b0;
      pin_b        <= 1'b0;
      pin_a_oe     <= 1'b0;
      pin_b_oe     <= 1'b0;
    end else begin
      cmp_output_a <= next_out_a;
      cmp_output_b <= next_out_b;
      pin_a        <= next_pin_a;
      pin_b        <= next_pin_b;
      pin_a_oe     <= next_oe_a;
      pin_b_oe     <= next_oe_b;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_take_a;
    @(posedge clk) disable iff (!rst_n)
      own_a |=> (pin_a == cmp_output_a);
  endproperty
  a_take_a: assert property (p_take_a) else $error("Pin A not following output A.");

  // Outputs still sit in reset at the release edge, so these checks start one edge later.
  property p_take_b;
    @(posedge clk) disable iff (!rst_n)
      (rst_n && !own_b) |=> (pin_b == $past(port_b));
  endproperty
  a_take_b: assert property (p_take_b) else $error("Pin B not following port B.");

  property p_oe;
    @(posedge clk) disable iff (!rst_n) rst_n |=> (pin_a_oe == $past(dir_a));
  endproperty
  a_oe: assert property (p_oe) else $error("Pin A driver not following direction.");

  property p_nonpwm_clear;
    @(posedge clk) disable iff (!rst_n)
      (wave == TCOC_WAVE_NONPWM && mode_b == 2'b10 && tmr.match_b) |=> !cmp_output_b;
  endproperty
  a_nonpwm_clear: assert property (p_nonpwm_clear) else $error("B not cleared.");

  property p_fast_b_off;
    @(posedge clk) disable iff (!rst_n)
      (wave == TCOC_WAVE_FAST && mode_b == 2'b01) |=> $stable(cmp_output_b);
  endproperty
  a_fast_b_off: assert property (p_fast_b_off) else $error("B moved in code 01.");

  sequence s_fast_bottom(logic [1:0] code);
    wave == TCOC_WAVE_FAST && mode_a == code && bottom;
  endsequence
  property p_noninv;
    @(posedge clk) disable iff (!rst_n) s_fast_bottom(2'b10) |=> cmp_output_a;
  endproperty
  a_noninv: assert property (p_noninv) else $error("A not set at bottom.");

  property p_inv;
    @(posedge clk) disable iff (!rst_n) s_fast_bottom(2'b11) |=> !cmp_output_a;
  endproperty
  a_inv: assert property (p_inv) else $error("A not cleared at bottom.");

  property p_top_ignore;
    @(posedge clk) disable iff (!rst_n)
      (wave == TCOC_WAVE_FAST && mode_a[1] && tmr.cmp_value_a == tmr.top && !bottom)
      |=> $stable(cmp_output_a);
  endproperty
  a_top_ignore: assert property (p_top_ignore) else $error("Match at top acted.");

  property p_oe_b;
    @(posedge clk) disable iff (!rst_n) rst_n |=> (pin_b_oe == $past(dir_b));
  endproperty
  a_oe_b: assert property (p_oe_b) else $error("Pin B driver wrong.");

  property p_other_hold;
    @(posedge clk) disable iff (!rst_n)
      (rst_n && wave == TCOC_WAVE_OTHER) |=> ($stable(cmp_output_a) && $stable(cmp_output_b));
  endproperty
  a_other_hold: assert property (p_other_hold) else $error("Output moved.");

  property p_nonpwm_toggle;
    @(posedge clk) disable iff (!rst_n)
      (wave == TCOC_WAVE_NONPWM && mode_a == TCOC_COM_TOGGLE && (tmr.match_a || force_a))
      |=> (cmp_output_a != $past(cmp_output_a));
  endproperty
  a_nonpwm_toggle: assert property (p_nonpwm_toggle) else $error("A not toggled.");

  property p_fast_toggle_a;
    @(posedge clk) disable iff (!rst_n)
      (wgm == TCOC_WGM_FAST_TOGGLE && mode_a == TCOC_COM_TOGGLE && tmr.match_a)
      |=> (cmp_output_a != $past(cmp_output_a));
  endproperty
  a_fast_toggle_a: assert property (p_fast_toggle_a) else $error("A not toggled.");

  property p_fast_b_port;
    @(posedge clk) disable iff (!rst_n)
      (rst_n && wave == TCOC_WAVE_FAST && mode_b == TCOC_COM_TOGGLE) |=> (pin_b == $past(port_b));
  endproperty
  a_fast_b_port: assert property (p_fast_b_port) else $error("Pin B taken over.");

  property p_bottom_b;
    @(posedge clk) disable iff (!rst_n)
      (wave == TCOC_WAVE_FAST && mode_b[1] && bottom) |=> (cmp_output_b != $past(mode_b[0]));
  endproperty
  a_bottom_b: assert property (p_bottom_b) else $error("B wrong after bottom.");

  property p_top_ignore_b;
    @(posedge clk) disable iff (!rst_n)
      (wave == TCOC_WAVE_FAST && mode_b[1] && tmr.cmp_value_b == tmr.top && !bottom)
      |=> $stable(cmp_output_b);
  endproperty
  a_top_ignore_b: assert property (p_top_ignore_b) else $error("Match at top acted.");

endmodule : tcoc_output_ctrl

// File: testbench/tcoc_pin_pad.sv
// Pad model for one compare output pin, as the board sees it.
// Assumes the level and the driver enable come straight from the stage.
`timescale 1ns/10ps
module tcoc_pin_pad (
  input  wire logic drv,
  input  wire logic oe,
  output logic      pad
);
  logic last = 1'b0;

  // A released pad has no pull, so it shows the opposite of its last level
  // instead of a value that the simulator would settle on its own.
  always @(drv or oe) begin
    if (oe) begin
      pad  = drv;
      last = drv;
    end else begin
      pad = ~last;
    end
  end
endmodule : tcoc_pin_pad

// File: testbench/tcoc_output_ctrl_tb.sv
// Self-checking bench for the compare output stage, with a cycle model.
// Assumes the package, the stage and the pad model are compiled first.
`timescale 1ns/10ps
module tcoc_output_ctrl_tb;
  import tcoc_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, chk_on = 1'b0;
  tcoc_bus_t   bus = '0;
  tcoc_timer_t tmr = '0;
  logic [1:0]  wgm_hi = 2'h0;
  logic        dir_a = 1'b0, dir_b = 1'b0, port_a = 1'b0, port_b = 1'b0;
  logic [7:0]  rdata, m_ctrl, m_rd;
  logic [3:0]  m_w;
  logic [15:0] t;
  logic        pin_a, pin_a_oe, pin_b, pin_b_oe, cmp_output_a, cmp_output_b, pad_a, pad_b;
  logic        oa, ob, m_oa, m_ob, m_pa, m_pb, m_ea, m_eb, m_fa, m_fb;
  logic        m_np, m_fp, m_own_a, m_own_b;
  int          seed = 25975, error_cnt = 0, checked = 0;
  // Each entry is {upper waveform bits, control byte}.
  logic [9:0]  cfg [13] = '{10'h00c, 10'h05c, 10'h0a0, 10'h0f0, 10'h190, 10'h360, 10'h1a1,
                            10'h3f2, 10'h353, 10'h153, 10'h3b3, 10'h0f1, 10'h1e2};

  tcoc_output_ctrl tcoc_output_ctrl_inst (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .tmr(tmr), .wgm_hi(wgm_hi), .dir_a(dir_a), .dir_b(dir_b), .port_a(port_a),
    .port_b(port_b), .pin_a(pin_a), .pin_a_oe(pin_a_oe), .pin_b(pin_b), .pin_b_oe(pin_b_oe),
    .cmp_output_a(cmp_output_a), .cmp_output_b(cmp_output_b));
  tcoc_pin_pad pad_a_inst (.drv(pin_a), .oe(pin_a_oe), .pad(pad_a));
  tcoc_pin_pad pad_b_inst (.drv(pin_b), .oe(pin_b_oe), .pad(pad_b));

  always #20 clk = ~clk;

  // Counter runs from zero to top; a match pulses where it meets a compare value.
  // Compare values drawn for each entry are never zero, so once they are set a match never lands on bottom.
  always @(posedge clk) begin
    tmr.count   <= (tmr.count >= tmr.top) ? 16'h0000 : tmr.count + 16'h0001;
    tmr.match_a <= ((tmr.count >= tmr.top) ? 16'h0000 : tmr.count + 16'h0001) == tmr.cmp_value_a;
    tmr.match_b <= ((tmr.count >= tmr.top) ? 16'h0000 : tmr.count + 16'h0001) == tmr.cmp_value_b;
    {dir_a, dir_b, port_a, port_b} <= 4'($random(seed));
  end

  // Next compare output level for one channel.
  function automatic logic nxt_out(logic [1:0] md, logic o, logic m, logic bt, logic at_top,
                                   logic is_a, logic [3:0] w);
    logic np;
    logic fp;
    np = w inside {4'h0, 4'h4, 4'hc};
    fp = w inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf};
    nxt_out = o;
    if (np && m) nxt_out = (md == 2'h1) ? ~o : (md == 2'h0) ? o : md[0];
    else if (fp && bt && md[1]) nxt_out = ~md[0];
    else if (fp && m && md[1] && !at_top) nxt_out = md[0];
    else if (fp && m && md == 2'h1 && is_a && w == 4'hf) nxt_out = ~o;
  endfunction : nxt_out

  // Cycle model of the stage; outputs land one edge after their causes.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {m_ctrl, m_rd, m_oa, m_ob, m_pa, m_pb, m_ea, m_eb, m_fa, m_fb} <= '0;
    end else begin
      m_w  = {wgm_hi, m_ctrl[1:0]};
      m_np = m_w inside {4'h0, 4'h4, 4'hc};
      m_fp = m_w inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf};
      // A force strobe counts as a match in non-PWM modes only.
      oa = nxt_out(m_ctrl[7:6], m_oa, tmr.match_a || (m_fa && m_np), tmr.count == TCOC_BOTTOM,
                   tmr.cmp_value_a == tmr.top, 1'b1, m_w);
      ob = nxt_out(m_ctrl[5:4], m_ob, tmr.match_b || (m_fb && m_np), tmr.count == TCOC_BOTTOM,
                   tmr.cmp_value_b == tmr.top, 1'b0, m_w);
      // Pin takeover; fast PWM code 01 leaves the port in charge, except on channel A in mode 15.
      m_own_a = (m_ctrl[7:6] != 2'h0) && !(m_fp && m_ctrl[7:6] == 2'h1 && m_w != 4'hf);
      m_own_b = (m_ctrl[5:4] != 2'h0) && !(m_fp && m_ctrl[5:4] == 2'h1);
      m_pa <= m_own_a ? oa : port_a;
      m_pb <= m_own_b ? ob : port_b;
      m_fa <= bus.wr && bus.addr == TCOC_ADDR_CTRL_A && bus.wdata[3];
      m_fb <= bus.wr && bus.addr == TCOC_ADDR_CTRL_A && bus.wdata[2];
      {m_ea, m_eb, m_oa, m_ob} <= {dir_a, dir_b, oa, ob};
      m_rd <= !bus.rd ? 8'h00 : (bus.addr == TCOC_ADDR_CTRL_A) ? m_ctrl & TCOC_CTRL_A_RW_MASK :
              (bus.addr == TCOC_ADDR_STATUS) ? {4'h0, m_eb, m_ea, m_ob, m_oa} : 8'h00;
      if (bus.wr && bus.addr == TCOC_ADDR_CTRL_A) m_ctrl <= bus.wdata & TCOC_CTRL_A_RW_MASK;
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Outputs are settled by the falling edge, so every cycle is compared there.
  always @(negedge clk) begin
    if (chk_on) begin
      check({4'h0, pin_b_oe, pin_a_oe, cmp_output_b, cmp_output_a},
            {4'h0, m_eb, m_ea, m_ob, m_oa});
      check({7'h0, pin_a}, {7'h0, m_pa});
      check({7'h0, pin_b}, {7'h0, m_pb});
      if (m_ea) check({7'h0, pad_a}, {7'h0, m_pa});
      if (m_eb) check({7'h0, pad_b}, {7'h0, m_pb});
      check(rdata, m_rd);
    end
  end

  // One bus cycle; the master moves its signals right after the edge.
  task automatic tick(input logic wr, input logic rd, input logic [1:0] ad, input logic [7:0] wd);
    @(posedge clk);
    bus <= '{addr: ad, wdata: wd, wr: wr, rd: rd};
  endtask : tick

  task automatic tally_and_finish;
    if (error_cnt == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Cut a hang short well beyond the expected run of about 850 cycles.
  initial begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end

  // Main sequence: each of the 13 mode bytes in cfg, force strobes, unmapped accesses.
  initial begin
    repeat (8) @(posedge clk);
    rst_n  <= 1'b1;
    chk_on <= 1'b1;
    foreach (cfg[i]) begin
      tick(1'b1, 1'b0, 2'h3, 8'hff);
      tick(1'b1, 1'b0, 2'h0, cfg[i][7:0]);
      tick(1'b0, 1'b1, 2'h0, 8'h00);
      wgm_hi <= cfg[i][9:8];
      t = 16'h0008 + 16'($random(seed) & 7);
      tmr.top <= t;
      tmr.cmp_value_a <= i[0] ? t : 16'h0001 + 16'($random(seed) & 7);
      tmr.cmp_value_b <= i[0] ? 16'h0001 + 16'($random(seed) & 7) : t;
      repeat (60) tick(1'b0, 1'($random(seed)), 2'($random(seed)), 8'h00);
    end
    // A second reset in mid-run must bring the control byte back to zero.
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (20) tick(1'b0, 1'b1, 2'($random(seed)), 8'h00);
    // Let the last read answer before the verdict.
    repeat (2) @(posedge clk);
    tally_and_finish();
  end
endmodule : tcoc_output_ctrl_tb
